// ==== bench/qsp_host_model.sv ====
// host controller model: strobe pair, selects, write beats
`timescale 1ns/1ps
module qsp_host_model (
    // strobe pair
    output logic k_o = 1'b0,
    output logic kn_o = 1'b1,
    // command and write data pins
    output logic rd_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic [19:0] addr_o = 20'h0,
    output logic [35:0] data_o = 36'h0
);
    // opposite phase, 5 mhz, far below the bypass limit
    always begin
        #100;
        k_o = ~k_o;
        kn_o = ~kn_o;
    end
    // select held across one main rise
    task automatic cmd(input logic rd, input logic [19:0] a,
                       input logic [143:0] d);
        @(posedge kn_o);
        rd_n_o = !rd;
        wr_n_o = rd;
        addr_o = a;
        @(posedge kn_o);
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = ~a;
        // each beat held a quarter period past its edge
        for (int i = 0; i < 4 && !rd; i++) begin
            data_o = d[36*i +: 36];
            if (i[0]) @(posedge kn_o);
            else @(posedge k_o);
            #50;
        end
        // stale bus would hide a late capture
        data_o = ~data_o;
    endtask
endmodule

// ==== bench/qsp_port_monitor.sv ====
// assertion checker on the sram port pins
`timescale 1ns/1ps
module qsp_port_monitor #(
    parameter DATA_W = 36
) (
    // clock and reset
    input logic clk_i,
    input logic reset_i,
    // watched pins
    input logic narrow_mode_i,
    input logic loop_enable_i,
    input logic strobe_i,
    input logic [DATA_W-1:0] read_data_out_o,
    input logic read_data_oe_o,
    input logic echo_strobe_o,
    input logic echo_strobe_n_o,
    input logic read_valid_flag_o,
    input logic loop_locked_o,
    input logic wr_beat_valid_o,
    input logic [DATA_W-1:0] wr_beat_data_o,
    input logic rd_req_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_valid_is_oe: assert property (
        read_valid_flag_o == read_data_oe_o) else $error("valid vs enable");
    a_valid_echo_edge: assert property (
        $changed(read_valid_flag_o) |->
        $changed(echo_strobe_o) || $changed(echo_strobe_n_o))
        else $error("valid moved off echo edge");
    a_data_echo_edge: assert property (
        $changed(read_data_out_o) |->
        $changed(echo_strobe_o) || $changed(echo_strobe_n_o))
        else $error("read data moved off echo edge");
    a_narrow_rd_zero: assert property (
        narrow_mode_i && read_data_oe_o |->
        read_data_out_o[DATA_W-1:18] == '0) else $error("upper read bits");
    a_narrow_wr_zero: assert property (
        narrow_mode_i && wr_beat_valid_o |->
        wr_beat_data_o[DATA_W-1:18] == '0) else $error("upper write bits");
    a_rd_req_gap: assert property (
        rd_req_valid_o |=> !rd_req_valid_o [*8]) else $error("read gap");
    a_echo_free_run: assert property (
        $rose(strobe_i) |-> ##[1:6] echo_strobe_o) else $error("echo idle");
    a_bypass_unlock: assert property (
        !loop_enable_i [*4] |-> !loop_locked_o) else $error("lock kept");
endmodule

// ==== bench/qsp_port_tb.sv ====
// self-checking bench for the sram port block
`timescale 1ns/1ps
module qsp_port_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic narrow_mode_i = 1'b0;
    logic loop_enable_i = 1'b0;
    logic strobe_i, strobe_n_i, read_sel_n_i, write_sel_n_i;
    logic [19:0] address_pins_i;
    logic [35:0] write_data_in_i, read_data_out_o, wr_beat_data_o;
    logic [35:0] rd_beat_data_i = 36'h0;
    logic read_data_oe_o, echo_strobe_o, echo_strobe_n_o, read_valid_flag_o;
    logic loop_locked_o, wr_beat_valid_o, rd_req_valid_o, oe_d;
    logic [21:0] wr_beat_addr_o, rd_req_addr_o;
    logic [31:0] rng = 32'h00017b5b;
    logic [21:0] qa[$];
    logic [35:0] qd[$];
    int fails = 0, samples_checked = 0, cyc = 0, t_req = 0, lat = 0;
    qsp_port #(.LOCK_NS(500)) i_dut (.*);
    qsp_host_model i_host (.k_o(strobe_i), .kn_o(strobe_n_i),
        .rd_n_o(read_sel_n_i), .wr_n_o(write_sel_n_i),
        .addr_o(address_pins_i), .data_o(write_data_in_i));
    always #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [35:0] msk(input logic [35:0] d);
        return narrow_mode_i ? {18'h0, d[17:0]} : d;
    endfunction
    task automatic chk(input logic [35:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #3;
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cyc++;
        if (wr_beat_valid_o || rd_req_valid_o) chk(qa.size() > 0, 1);
        if (wr_beat_valid_o) begin
            chk(wr_beat_addr_o, qa.pop_front());
            chk(wr_beat_data_o, qd.pop_front());
        end
        if (rd_req_valid_o) begin
            chk(rd_req_addr_o, qa.pop_front());
            t_req = cyc;
        end
        if (read_data_oe_o && !oe_d) chk((cyc - t_req + 4) / 8, lat);
        if (read_data_oe_o) chk(read_data_out_o, msk(rd_beat_data_i));
        oe_d <= read_data_oe_o;
    end
    task automatic op(input logic rd);
        logic [159:0] r;
        r = {xs(), xs(), xs(), xs(), xs()};
        if (rd) begin
            rd_beat_data_i = r[35:0];
            lat = loop_enable_i ? 2 : 1;
            qa.push_back({r[155:136], 2'h0});
        end else begin
            for (int i = 0; i < 4; i++) begin
                qa.push_back({r[155:136], i[1:0]});
                qd.push_back(msk(r[36*i +: 36]));
            end
        end
        i_host.cmd(rd, r[155:136], r[143:0]);
        tick(40);
    endtask
    task automatic wrap_up;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
    initial begin
        tick(8);
        reset_i = 1'b0;
        tick(40);
        chk(loop_locked_o, 0);
        op(1);
        op(0);
        loop_enable_i = 1'b1;
        tick(15);
        chk(loop_locked_o, 0);
        tick(15);
        chk(loop_locked_o, 1);
        for (int n = 0; n < 2; n++) begin
            narrow_mode_i = n[0];
            repeat (3) begin
                op(0);
                op(1);
            end
        end
        loop_enable_i = 1'b0;
        tick(6);
        chk(loop_locked_o, 0);
        op(1);
        chk(qa.size(), 0);
        wrap_up();
    end
endmodule
bind qsp_port qsp_port_monitor #(.DATA_W(DATA_W)) i_mon (.*);

// ==== hw/qsp_port.v ====
// device side port logic of the quad-rate burst-of-four sram
`timescale 1ns/1ps
`include "qsp_defines.vh"
// Notes on behaviour
// - address and selects sampled only at main strobe rising edge
// - write beats taken at rising edges of both input strobes
// - echo strobes toggle always, even while read data is idle
// - echo strobe edges launched together with read data changes
// - delay-loop disable low bypasses loop and clears lock
// - disable high starts loop; locked only after lock time
// - loop off gives one-cycle read latency; host limits to 167 MHz
// - valid flag high exactly while read data driven, echo aligned
// - address ignored in cycles with no read or write selected
// - narrow mode uses write bits 0..17 only
// - narrow mode drives read bits 0..17, upper bits unused
// - read bus driven only in answer to read commands
// - write select low registers address and starts a write
// - read select low registers address and starts a read
// - each access is four beats over two cycles
// - first read beat one cycle after command (two with loop locked), then alternating
module qsp_port #(
    parameter DATA_W = `QSP_DATA_W,
    parameter ADDR_W = `QSP_ADDR_W,
    parameter LOCK_NS = `QSP_LOCK_NS
) (
    // clock, reset, enable
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // configuration
    input wire narrow_mode_i,
    input wire loop_enable_i,
    // input strobes and command pins
    input wire strobe_i,
    input wire strobe_n_i,
    input wire read_sel_n_i,
    input wire write_sel_n_i,
    input wire [ADDR_W-1:0] address_pins_i,
    input wire [DATA_W-1:0] write_data_in_i,
    // read side pins
    output reg [DATA_W-1:0] read_data_out_o,
    output reg read_data_oe_o,
    output reg echo_strobe_o,
    output reg echo_strobe_n_o,
    output reg read_valid_flag_o,
    output wire loop_locked_o,
    // user side: write beats and read requests
    output reg wr_beat_valid_o,
    output reg [ADDR_W+1:0] wr_beat_addr_o,
    output reg [DATA_W-1:0] wr_beat_data_o,
    output reg rd_req_valid_o,
    output reg [ADDR_W+1:0] rd_req_addr_o,
    input wire [DATA_W-1:0] rd_beat_data_i
);
    localparam LOCK_CYC = (LOCK_NS + `QSP_CLK_NS - 1) / `QSP_CLK_NS;
    localparam CW = 16;
    // sized copies so counters take them without dropping bits
    localparam [CW-1:0] LOCK_LAST = LOCK_CYC - 1;
    localparam [1:0] LAT_DLL = `QSP_LAT_DLL;
    localparam [1:0] LAT_BYP = `QSP_LAT_BYP;
    ////////////////////////////////////////////////////////////////////////
    wire k_rise;
    wire kn_rise;
    wire loop_lvl;
    reg [ADDR_W-1:0] rs_sync1;
    reg [ADDR_W-1:0] rs_sync2;
    reg [DATA_W-1:0] d_sync1;
    reg [DATA_W-1:0] d_sync2;
    reg [3:0] sel_sync;
    qsp_sync u_k (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .async_i(strobe_i), .level_o(), .rise_o(k_rise));
    qsp_sync u_kn (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .async_i(strobe_n_i), .level_o(), .rise_o(kn_rise));
    qsp_sync u_dl (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .async_i(loop_enable_i), .level_o(loop_lvl), .rise_o());
    // buses share the strobe's two-flop delay so they line up with edges
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rs_sync1 <= {ADDR_W{1'b0}};
            rs_sync2 <= {ADDR_W{1'b0}};
            d_sync1 <= {DATA_W{1'b0}};
            d_sync2 <= {DATA_W{1'b0}};
            sel_sync <= 4'hf;
        end else if (ce_i) begin
            rs_sync1 <= address_pins_i;
            rs_sync2 <= rs_sync1;
            d_sync1 <= write_data_in_i;
            d_sync2 <= d_sync1;
            sel_sync <= {sel_sync[1:0], read_sel_n_i, write_sel_n_i};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // delay-loop lock state
    reg [2:0] lk_state;
    reg [2:0] next_lk_state;
    reg [CW-1:0] lk_cnt;
    always @* begin
        next_lk_state = lk_state;
        case (lk_state)
            `QSP_ST_IDLE: if (loop_lvl) next_lk_state = `QSP_ST_WAIT;
            `QSP_ST_WAIT: begin
                if (!loop_lvl)
                    next_lk_state = `QSP_ST_IDLE;
                else if (lk_cnt == LOCK_LAST)
                    next_lk_state = `QSP_ST_LOCK;
            end
            `QSP_ST_LOCK: if (!loop_lvl) next_lk_state = `QSP_ST_IDLE;
            default: next_lk_state = `QSP_ST_IDLE;
        endcase
    end
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lk_state <= `QSP_ST_IDLE;
            lk_cnt <= {CW{1'b0}};
        end else if (ce_i) begin
            lk_state <= next_lk_state;
            if (lk_state != `QSP_ST_WAIT)
                lk_cnt <= {CW{1'b0}};
            else
                lk_cnt <= lk_cnt + 16'h0001;
        end
    end
    assign loop_locked_o = (lk_state == `QSP_ST_LOCK);
    ////////////////////////////////////////////////////////////////////////
    // command capture and write beats
    // selects count only at a main strobe rise
    wire rd_cmd = k_rise & ~sel_sync[3];
    wire wr_cmd = k_rise & ~sel_sync[2];
    wire wr_start;
    wire [DATA_W-1:0] wmask;
    reg [ADDR_W-1:0] wr_addr;
    reg [ADDR_W-1:0] wr_next_addr;
    reg wr_pend;
    reg [2:0] wr_beat;
    // first beat on the next main rise
    assign wr_start = k_rise & wr_pend;
    // upper write bits unused in narrow mode
    assign wmask = narrow_mode_i ?
        {{(DATA_W-`QSP_HALF_W){1'b0}}, {`QSP_HALF_W{1'b1}}} : {DATA_W{1'b1}};
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_addr <= {ADDR_W{1'b0}};
            wr_next_addr <= {ADDR_W{1'b0}};
            wr_pend <= 1'b0;
            wr_beat <= 3'h0;
            wr_beat_valid_o <= 1'b0;
            wr_beat_addr_o <= {(ADDR_W+2){1'b0}};
            wr_beat_data_o <= {DATA_W{1'b0}};
            rd_req_valid_o <= 1'b0;
            rd_req_addr_o <= {(ADDR_W+2){1'b0}};
        end else if (ce_i) begin
            wr_beat_valid_o <= 1'b0;
            rd_req_valid_o <= 1'b0;
            if (wr_start)
                wr_pend <= 1'b0;
            // new command wins over the clear
            if (wr_cmd) begin
                wr_next_addr <= rs_sync2;
                wr_pend <= 1'b1;
            end
            // beats on main and inverted strobe rises
            if (wr_start) begin
                wr_beat_valid_o <= 1'b1;
                wr_beat_addr_o <= {wr_next_addr, 2'h0};
                wr_beat_data_o <= d_sync2 & wmask;
                wr_addr <= wr_next_addr;
                wr_beat <= 3'h1;
            end else if ((k_rise || kn_rise) && wr_beat != 3'h0) begin
                wr_beat_valid_o <= 1'b1;
                wr_beat_addr_o <= {wr_addr, wr_beat[1:0]};
                wr_beat_data_o <= d_sync2 & wmask;
                wr_beat <= (wr_beat == `QSP_BEATS - 1) ?
                    3'h0 : wr_beat + 3'h1;
            end
            if (rd_cmd) begin
                rd_req_valid_o <= 1'b1;
                rd_req_addr_o <= {rs_sync2, 2'h0};
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // read pipeline and echo strobes
    wire any_rise;
    wire rd_go;
    reg [1:0] rd_wait;
    reg [2:0] rd_beat;
    assign any_rise = k_rise | kn_rise;
    // burst opens on the main rise ending the latency
    assign rd_go = k_rise & (rd_wait == 2'h1);
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_wait <= 2'h0;
            rd_beat <= 3'h0;
            read_data_out_o <= {DATA_W{1'b0}};
            read_data_oe_o <= 1'b0;
            read_valid_flag_o <= 1'b0;
            echo_strobe_o <= 1'b0;
            echo_strobe_n_o <= 1'b1;
        end else if (ce_i) begin
            if (k_rise) begin
                echo_strobe_o <= 1'b1;
                echo_strobe_n_o <= 1'b0;
            end else if (kn_rise) begin
                echo_strobe_o <= 1'b0;
                echo_strobe_n_o <= 1'b1;
            end
            // latency follows loop lock at command time
            if (rd_cmd)
                rd_wait <= loop_locked_o ? LAT_DLL : LAT_BYP;
            else if (k_rise && rd_wait != 2'h0)
                rd_wait <= rd_wait - 2'h1;
            if (any_rise && (rd_go || rd_beat != 3'h0)) begin
                // drive only for reads; narrow mask
                read_data_out_o <= rd_beat_data_i & wmask;
                read_data_oe_o <= 1'b1;
                read_valid_flag_o <= 1'b1;
                if (rd_go)
                    rd_beat <= 3'h1;
                else if (rd_beat == `QSP_BEATS - 1)
                    rd_beat <= 3'h0;
                else
                    rd_beat <= rd_beat + 3'h1;
            end else if (any_rise) begin
                read_data_oe_o <= 1'b0;
                read_valid_flag_o <= 1'b0;
            end
        end
    end
endmodule

// ==== hw/qsp_sync.v ====
// two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`include "qsp_defines.vh"
module qsp_sync (
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // asynchronous level in, synced level and edge out
    input wire async_i,
    output wire level_o,
    output wire rise_o
);
    reg meta;
    reg sync;
    reg prev;
    // no edge until prev holds a real sample: a pin idling high
    // would otherwise fake a rise right after reset
    reg [2:0] warm;
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            warm <= 3'h0;
        end else if (ce_i) begin
            meta <= async_i;
            sync <= meta;
            prev <= sync;
            warm <= {warm[1:0], 1'b1};
        end
    end
    assign level_o = sync;
    assign rise_o = ce_i & warm[2] & sync & ~prev;
endmodule

// ==== include/qsp_defines.vh ====
// constants for the quad-rate burst sram port block
`ifndef QSP_DEFINES_VH
`define QSP_DEFINES_VH
`define QSP_DATA_W 36
`define QSP_HALF_W 18
`define QSP_ADDR_W 20
`define QSP_LOCK_NS 20480
`define QSP_CLK_NS 25
`define QSP_LAT_DLL 2
`define QSP_LAT_BYP 1
`define QSP_BEATS 4
`define QSP_ST_IDLE 3'h1
`define QSP_ST_WAIT 3'h2
`define QSP_ST_LOCK 3'h4
`endif
